// file: core/tx_shape_pkg.sv
// constants shared by the transmit frame shaping block
package tx_shape_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_LAST_BYTE   = 8'h2e; // tx_last_byte_control
  localparam logic [7:0] ADDR_PULSE_WIDTH = 8'h2f; // tx_pulse_width
  localparam logic [7:0] ADDR_BURST_LEN   = 8'h30; // tx_burst_length

  // field positions
  localparam int GRID_BIT      = 4;
  localparam int SEND_DATA_BIT = 3;
  localparam int LAST_BITS_LSB = 0;
  localparam int SYM1_LSB      = 4;
  localparam int SYM0_LSB      = 0;

  // reset values
  localparam logic [4:0] LAST_BYTE_RST   = 5'h00;
  localparam logic [7:0] PULSE_WIDTH_RST = 8'h00;
  localparam logic [5:0] BURST_LEN_RST   = 6'h00;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_NS   = 10;
  localparam int ETU_NS   = 9440;           // one bit at the base rate
  localparam int ETU_CLKS = ETU_NS / CLK_NS; // longest time: round down
  localparam int ETU_W    = $clog2(ETU_CLKS);
  localparam int FIFO_DEPTH = 8;

  // burst length in bits, same mapping for both symbol fields
  function automatic logic [8:0] burst_bits(input logic [2:0] code);
    case (code)
      3'h0:    burst_bits = 9'h008;
      3'h1:    burst_bits = 9'h010;
      3'h2:    burst_bits = 9'h020;
      3'h3:    burst_bits = 9'h030;
      3'h4:    burst_bits = 9'h040;
      3'h5:    burst_bits = 9'h060;
      3'h6:    burst_bits = 9'h080;
      default: burst_bits = 9'h100;
    endcase
  endfunction

  typedef enum logic [2:0] {S_IDLE, S_ALIGN, S_BURST, S_START, S_DATA, S_STOP} tx_state_t;
endpackage

// file: core/tx_byte_fifo.sv
// byte buffer between the host data port and the bit shifter
module tx_byte_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  input  wire logic [WIDTH-1:0] i_in_data,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  output logic [WIDTH-1:0]      o_out_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic [AW:0]      count_next;
  logic             push;
  logic             pop;

  // ---------------------------------------------------------------
  // handshakes
  // ---------------------------------------------------------------
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;
  assign o_out_data  = mem[rd_ptr_reg];
  assign o_out_valid = (count_reg != '0);

  always_comb begin
    count_next = count_reg;
    if (push && !pop) count_next = count_reg + 1'b1;
    else if (pop && !push) count_next = count_reg - 1'b1;
  end

  // storage and pointers; depth is assumed a power of two
  always_ff @(posedge i_clk) begin
    if (push) mem[wr_ptr_reg] <= i_in_data;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
      o_in_ready <= 1'b1;
    end else begin
      if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop) rd_ptr_reg <= rd_ptr_reg + 1'b1;
      count_reg  <= count_next;
      o_in_ready <= (count_next != FULL_CNT); // registered so the port comes from a flop
    end
  end
endmodule

// file: core/tx_frame_shaper.sv
// transmit frame shaping: config registers, grid alignment, bit shifter, pulse and burst
// ---------------------------------------------------------------
// transmit frame shaper top
// ---------------------------------------------------------------
// Function
// [R01] with grid bit set, transmission starts land on whole ETU boundaries
// [R02] send-data clear sends one symbol pattern only; set sends data bytes
// [R03] last-byte field gives bit count of final byte, lsb sent first
// [R04] last-byte field zero sends all eight bits of final byte
// [R05] omitted final-byte bits are the top ones; nothing follows them
// [R06] each miller data pulse lasts pulse width plus one clocks
// [R07] a pulse is cut off at the end of its bit
// [R08] pulse start position within a bit comes from a separate setting
// [R09] pulse width used only with miller coding, ignored otherwise
// [R10] the same pulse width shapes start and stop symbols
// [R11] burst protocols emit unmodulated subcarrier for programmed burst length
// [R12] burst level comes from separate burst control, not the length register
// [R13] symbol0 codes 0..7 give 8,16,32,48,64,96,128,256 burst bits
// [R14] bits 6..4 set symbol1 burst length, bits 2..0 symbol0
// [R15] symbol1 field uses the same code mapping as symbol0
// [R16] reserved register bits read zero and ignore writes
module tx_frame_shaper
  import tx_shape_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic [7:0] i_reg_addr,
  input  wire logic       i_reg_wr,
  input  wire logic [7:0] i_reg_wdata,
  input  wire logic       i_reg_rd,
  output logic [7:0]      o_reg_rdata,
  input  wire logic [7:0] i_tx_byte,
  input  wire logic       i_tx_last,
  input  wire logic       i_tx_valid,
  output logic            o_tx_ready,
  input  wire logic       i_tx_start,
  input  wire logic       i_miller_en,
  input  wire logic [7:0] i_pulse_start_position,
  input  wire logic       i_burst_level,
  input  wire logic       i_symbol_select,
  output logic            o_mod,
  output logic            o_busy,
  output logic            o_tx_done
);
  import tx_shape_pkg::*;

  localparam logic [ETU_W-1:0] ETU_LAST = ETU_W'(ETU_CLKS - 1);

  logic [1:0]       rst_sync_reg;
  logic             rst_n;
  logic [4:0]       last_ctrl_reg;
  logic [7:0]       pulse_width_reg;
  logic [5:0]       burst_len_reg;
  tx_state_t        state_reg;
  tx_state_t        state_next;
  logic [ETU_W-1:0] grid_cnt;
  logic [ETU_W-1:0] bit_cnt;
  logic             bit_end;
  logic [8:0]       burst_cnt;
  logic [8:0]       burst_total_reg;
  logic [7:0]       byte_reg;
  logic             last_reg;
  logic [3:0]       bits_left_reg;
  logic             data_mode_reg;
  logic [8:0]       fifo_dout;
  logic             fifo_valid;
  logic             pop;
  logic             load_byte;
  logic             pulse;
  logic [10:0]      pulse_end;
  logic             mod_next;
  logic [2:0]       last_bits;

  assign last_bits = last_ctrl_reg[LAST_BITS_LSB +: 3];

  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  // asynchronous assert, release after two edges
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) rst_sync_reg <= 2'b00;
    else rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  assign rst_n = rst_sync_reg[1];

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  // reserved bits are simply not stored
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      last_ctrl_reg   <= LAST_BYTE_RST;
      pulse_width_reg <= PULSE_WIDTH_RST;
      burst_len_reg   <= BURST_LEN_RST;
    end else if (i_reg_wr) begin
      case (i_reg_addr)
        ADDR_LAST_BYTE:   last_ctrl_reg <= i_reg_wdata[4:0];   // [R16]
        ADDR_PULSE_WIDTH: pulse_width_reg <= i_reg_wdata;
        ADDR_BURST_LEN:   burst_len_reg <= {i_reg_wdata[6:4], i_reg_wdata[2:0]}; // [R14] [R16]
        default: ;
      endcase
    end
  end

  // read data held until the next read; unmapped addresses answer zero
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) o_reg_rdata <= 8'h00;
    else if (i_reg_rd) begin
      case (i_reg_addr)
        ADDR_LAST_BYTE:   o_reg_rdata <= {3'b000, last_ctrl_reg};                        // [R16]
        ADDR_PULSE_WIDTH: o_reg_rdata <= pulse_width_reg;
        ADDR_BURST_LEN:   o_reg_rdata <= {1'b0, burst_len_reg[5:3], 1'b0, burst_len_reg[2:0]}; // [R16]
        default:          o_reg_rdata <= 8'h00;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // byte buffer
  // ---------------------------------------------------------------
  tx_byte_fifo #(
    .WIDTH (9),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_clk       (i_clk),
    .i_rst_n     (rst_n),
    .i_in_data   ({i_tx_last, i_tx_byte}),
    .i_in_valid  (i_tx_valid),
    .o_in_ready  (o_tx_ready),
    .o_out_data  (fifo_dout),
    .o_out_valid (fifo_valid),
    .i_out_ready (pop)
  );

  // ---------------------------------------------------------------
  // timing counters
  // ---------------------------------------------------------------
  // free running ETU grid; bit counter restarts at every transmission start
  assign bit_end = (bit_cnt == ETU_LAST);

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) grid_cnt <= '0;
    else grid_cnt <= (grid_cnt == ETU_LAST) ? '0 : grid_cnt + 1'b1;
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) bit_cnt <= '0;
    else if (state_reg == S_IDLE || state_reg == S_ALIGN || bit_end) bit_cnt <= '0;
    else bit_cnt <= bit_cnt + 1'b1;
  end

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  // a byte is fetched after the start symbol and after each non-final byte
  assign load_byte = bit_end && ((state_reg == S_START) ||
                     (state_reg == S_DATA && bits_left_reg == 4'd1 && !last_reg));
  assign pop = load_byte && fifo_valid;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      S_IDLE: begin
        if (i_tx_start) begin
          if (last_ctrl_reg[GRID_BIT]) state_next = S_ALIGN;
          else state_next = last_ctrl_reg[SEND_DATA_BIT] ? S_START : S_BURST; // [R02]
        end
      end
      S_ALIGN: begin
        // leave only on the grid wrap so the first active cycle sits on a boundary
        if (grid_cnt == ETU_LAST) state_next = data_mode_reg ? S_START : S_BURST; // [R01]
      end
      S_BURST: if (bit_end && burst_cnt == burst_total_reg - 9'd1) state_next = S_IDLE; // [R11]
      S_START: if (bit_end) state_next = fifo_valid ? S_DATA : S_STOP;
      S_DATA: begin
        if (bit_end && bits_left_reg == 4'd1) begin
          if (last_reg || !fifo_valid) state_next = S_STOP; // [R05]
        end
      end
      S_STOP:  if (bit_end) state_next = S_IDLE;
      default: state_next = S_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) state_reg <= S_IDLE;
    else state_reg <= state_next;
  end

  // mode and burst length are frozen at the start request
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      data_mode_reg   <= 1'b0;
      burst_total_reg <= 9'h008;
    end else if (state_reg == S_IDLE && i_tx_start) begin
      data_mode_reg   <= last_ctrl_reg[SEND_DATA_BIT]; // [R02]
      burst_total_reg <= i_symbol_select ? burst_bits(burst_len_reg[5:3])  // [R15]
                                         : burst_bits(burst_len_reg[2:0]); // [R13]
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) burst_cnt <= '0;
    else if (state_reg != S_BURST) burst_cnt <= '0;
    else if (bit_end) burst_cnt <= burst_cnt + 9'd1;
  end

  // ---------------------------------------------------------------
  // bit shifter, lsb first
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      byte_reg      <= 8'h00;
      last_reg      <= 1'b0;
      bits_left_reg <= 4'd0;
    end else if (pop) begin
      byte_reg <= fifo_dout[7:0];
      last_reg <= fifo_dout[8];
      if (fifo_dout[8] && last_bits != 3'd0) bits_left_reg <= {1'b0, last_bits}; // [R03]
      else bits_left_reg <= 4'd8;                                                 // [R04]
    end else if (state_reg == S_DATA && bit_end) begin
      byte_reg      <= {1'b0, byte_reg[7:1]};
      bits_left_reg <= bits_left_reg - 4'd1;
    end
  end

  // ---------------------------------------------------------------
  // modulation
  // ---------------------------------------------------------------
  // pulse window is bounded by the bit counter wrap, so it never spills over
  assign pulse_end = 11'(i_pulse_start_position) + 11'(pulse_width_reg) + 11'd1; // [R06]
  assign pulse = (11'(bit_cnt) >= 11'(i_pulse_start_position)) && (11'(bit_cnt) < pulse_end); // [R07] [R08]

  always_comb begin
    case (state_reg)
      S_BURST:         mod_next = i_burst_level;                    // [R12]
      S_START, S_STOP: mod_next = i_miller_en ? pulse : 1'b1;       // [R10]
      S_DATA:          mod_next = i_miller_en ? (pulse && byte_reg[0]) : byte_reg[0]; // [R09]
      default:         mod_next = 1'b0;
    endcase
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_mod     <= 1'b0;
      o_busy    <= 1'b0;
      o_tx_done <= 1'b0;
    end else begin
      o_mod     <= mod_next;
      o_busy    <= (state_next != S_IDLE);
      o_tx_done <= (state_reg != S_IDLE && state_reg != S_ALIGN && state_next == S_IDLE);
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_grid_start;
    @(posedge i_clk) disable iff (!rst_n)
    (state_reg == S_ALIGN && grid_cnt == ETU_LAST) |=> (state_reg != S_ALIGN && grid_cnt == '0);
  endproperty
  a_grid_start: assert property (p_grid_start) else $error("start off the ETU grid"); // [R01]

  property p_mode_path;
    @(posedge i_clk) disable iff (!rst_n)
    (state_reg == S_DATA |-> data_mode_reg) and (state_reg == S_BURST |-> !data_mode_reg);
  endproperty
  a_mode_path: assert property (p_mode_path) else $error("data or symbol path in wrong mode"); // [R02]

  property p_last_count;
    @(posedge i_clk) disable iff (!rst_n)
    (pop && fifo_dout[8] && last_bits != 3'd0) |=> bits_left_reg == {1'b0, $past(last_bits)};
  endproperty
  a_last_count: assert property (p_last_count) else $error("final byte bit count wrong"); // [R03]

  property p_last_full;
    @(posedge i_clk) disable iff (!rst_n)
    (pop && (!fifo_dout[8] || last_bits == 3'd0)) |=> bits_left_reg == 4'd8;
  endproperty
  a_last_full: assert property (p_last_full) else $error("full byte not eight bits"); // [R04]

  property p_last_stop;
    @(posedge i_clk) disable iff (!rst_n)
    (state_reg == S_DATA && last_reg && bits_left_reg == 4'd1 && bit_end) |=> state_reg == S_STOP;
  endproperty
  a_last_stop: assert property (p_last_stop) else $error("bits sent after final bit"); // [R05]

  property p_pulse_len;
    @(posedge i_clk) disable iff (!rst_n)
    (i_miller_en && state_reg == S_START && $past(state_reg) == S_START && $fell(pulse)
      && $past(bit_cnt) != ETU_LAST) |-> 11'($past(bit_cnt)) + 11'd1 == $past(pulse_end);
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("pulse length not width plus one"); // [R06]

  property p_pulse_cut;
    @(posedge i_clk) disable iff (!rst_n)
    // a zero start position opens the next bit's own pulse at once, which is not a spill-over
    (state_reg == S_START && bit_end && i_pulse_start_position != 8'h00) |=> !pulse;
  endproperty
  a_pulse_cut: assert property (p_pulse_cut) else $error("pulse crossed bit end"); // [R07]

  property p_plain_coding;
    @(posedge i_clk) disable iff (!rst_n)
    (!i_miller_en && state_reg == S_DATA) |=> o_mod == $past(byte_reg[0]);
  endproperty
  a_plain_coding: assert property (p_plain_coding) else $error("width applied outside miller"); // [R09]

  property p_burst_level;
    @(posedge i_clk) disable iff (!rst_n)
    state_reg == S_BURST |=> o_mod == $past(i_burst_level);
  endproperty
  a_burst_level: assert property (p_burst_level) else $error("burst level wrong"); // [R12]

  property p_burst_table;
    @(posedge i_clk) disable iff (!rst_n)
    (state_reg == S_IDLE && i_tx_start && i_symbol_select)
      |=> burst_total_reg == burst_bits($past(burst_len_reg[5:3]));
  endproperty
  a_burst_table: assert property (p_burst_table) else $error("symbol1 burst length wrong"); // [R15]

  property p_reserved;
    @(posedge i_clk) disable iff (!rst_n)
    (i_reg_rd && i_reg_addr == ADDR_BURST_LEN) |=> (o_reg_rdata[7] == 1'b0 && o_reg_rdata[3] == 1'b0);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit reads one"); // [R16]
endmodule

// file: verification/card_model.sv
// card side model: watches the field modulation and logs pulses and bit samples
module card_model (
  input wire logic i_clk,
  input wire logic i_mod,
  input wire logic i_done
);
  timeunit 1ns;
  timeprecision 1ns;

  int   cyc        = 0;
  int   first_rise = -1;
  int   run        = 0;
  int   ph         = -1;
  int   runs[$];
  logic bits[$];

  // the card has no clock of its own in the frame: the bit grid is taken
  // from the first rise, so bit samples only make sense without miller
  always @(posedge i_clk) begin
    cyc++;
    if (i_mod) begin
      run++;
    end else if (run != 0) begin
      runs.push_back(run);
      run = 0;
    end
    if (ph >= 0) begin
      if (ph == 472) begin
        bits.push_back(i_mod);
      end
      ph = (ph == 943) ? 0 : ph + 1;
    end
    if (i_mod && first_rise < 0) begin
      first_rise = cyc;
      ph = 1;
    end
    if (i_done) begin
      ph = -1;
    end
  end

  // logs are emptied by the bench before each frame
  task automatic clear();
    runs.delete();
    bits.delete();
    first_rise = -1;
    ph = -1;
    run = 0;
  endtask
endmodule

// file: verification/tb_tx_frame_shaper.sv
// self-checking bench for the transmit frame shaper
module tb_tx_frame_shaper;
  timeunit 1ns;
  timeprecision 1ns;
  import tx_shape_pkg::*;

  logic       clk;
  logic       rst_n;
  logic       reg_wr;
  logic       reg_rd;
  logic       tx_last;
  logic       tx_valid;
  logic       tx_start;
  logic       miller_en;
  logic       burst_level;
  logic       symbol_select;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] tx_byte;
  logic [7:0] pulse_pos;
  logic [7:0] reg_rdata;
  logic       tx_ready;
  logic       mod;
  logic       busy;
  logic       tx_done;
  logic [7:0] q[$];
  logic       exp[$];
  int         n_mismatch  = 0;
  int         check_count = 0;
  int         lat0;

  tx_frame_shaper u_dut (
    .i_clk(clk), .i_rst_n(rst_n), .i_reg_addr(reg_addr), .i_reg_wr(reg_wr),
    .i_reg_wdata(reg_wdata), .i_reg_rd(reg_rd), .o_reg_rdata(reg_rdata),
    .i_tx_byte(tx_byte), .i_tx_last(tx_last), .i_tx_valid(tx_valid),
    .o_tx_ready(tx_ready), .i_tx_start(tx_start), .i_miller_en(miller_en),
    .i_pulse_start_position(pulse_pos), .i_burst_level(burst_level),
    .i_symbol_select(symbol_select), .o_mod(mod), .o_busy(busy), .o_tx_done(tx_done)
  );

  card_model u_card (.i_clk(clk), .i_mod(mod), .i_done(tx_done));

  // ---------------------------------------------------------------
  // compare and bus tasks
  // ---------------------------------------------------------------
  task automatic chk8(input logic [7:0] got, input logic [7:0] want, input string msg);
    check_count++;
    if (got !== want) begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, want);
    end
  endtask

  task automatic chk_int(input int got, input int want, input string msg);
    check_count++;
    if (got != want) begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %0d exp %0d", $time, msg, got, want);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // read data stands from the cycle after the read edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    #1 d = reg_rdata;
  endtask

  // byte held until the edge that sees ready high
  task automatic push(input logic [7:0] b, input logic last);
    tx_byte <= b;
    tx_last <= last;
    tx_valid <= 1'b1;
    do @(posedge clk); while (tx_ready !== 1'b1);
  endtask

  // writes the frame setting, queues q and works out the expected bits
  task automatic load(input logic [7:0] cfg);
    int n;
    wr(ADDR_LAST_BYTE, cfg);
    exp = {1'b1};
    foreach (q[i]) begin
      n = (i == q.size() - 1 && cfg[2:0] != 3'h0) ? int'(cfg[2:0]) : 8;
      for (int k = 0; k < n; k++) exp.push_back(q[i][k]);
      push(q[i], i == q.size() - 1);
    end
    exp.push_back(1'b1);
    tx_valid <= 1'b0;
  endtask

  // starts after gap idle cycles; lat is start edge to first modulation
  task automatic send(input int gap, output int lat);
    int st;
    u_card.clear();
    repeat (gap + 1) @(posedge clk);
    tx_start <= 1'b1;
    @(posedge clk);
    tx_start <= 1'b0;
    #1 st = u_card.cyc;
    @(posedge clk);
    #1 chk8({7'h0, busy}, 8'h01, "busy");
    do @(posedge clk); while (tx_done !== 1'b1);
    chk8({7'h0, busy}, 8'h00, "busy at done");
    repeat (4) @(posedge clk);
    lat = u_card.first_rise - st;
  endtask

  task automatic chk_bits();
    chk_int(u_card.bits.size(), exp.size(), "bit count");
    foreach (exp[i]) chk8({7'h0, u_card.bits[i]}, {7'h0, exp[i]}, "bit");
  endtask

  task automatic chk_runs(input int n, input int len);
    chk_int(u_card.runs.size(), n, "pulse count");
    foreach (u_card.runs[i]) chk_int(u_card.runs[i], len, "pulse length");
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_regs();
    logic [7:0] a[3] = '{ADDR_LAST_BYTE, ADDR_PULSE_WIDTH, ADDR_BURST_LEN};
    logic [7:0] m[3] = '{8'h1f, 8'hff, 8'h77};
    logic [7:0] d;
    foreach (a[i]) begin
      rd(a[i], d);
      chk8(d, 8'h00, "reset value");
      wr(a[i], 8'hff);
      rd(a[i], d);
      chk8(d, m[i], "readback");
    end
    wr(8'h31, 8'h5a);
    rd(8'h31, d);
    chk8(d, 8'h00, "unmapped read");
  endtask

  // width register set but not miller: whole-bit levels expected
  task automatic t_grid();
    int lb;
    int lc;
    int rc;
    wr(ADDR_PULSE_WIDTH, 8'h40);
    q = '{8'h02};
    load(8'h0a);
    send(0, lat0);
    chk_bits();
    chk_int(u_card.runs[0], ETU_CLKS, "start bit");
    chk_int(lat0, 2, "no grid wait");
    q = '{8'hfe};
    load(8'h09);
    send(7, lb);
    chk_bits();
    chk_int(lb, lat0, "latency off grid");
    q = '{8'h01};
    load(8'h19);
    send(0, lc);
    rc = u_card.first_rise;
    load(8'h19);
    send(3, lc);
    chk_int((u_card.first_rise - rc) % ETU_CLKS, 0, "grid phase");
  endtask

  task automatic t_miller();
    int lm;
    miller_en <= 1'b1;
    pulse_pos <= 8'h64;
    wr(ADDR_PULSE_WIDTH, 8'h09);
    q = '{8'h02};
    load(8'h0a);
    send(0, lm);
    chk_runs(3, 10);
    chk_int(lm, lat0 + 100, "pulse start");
    pulse_pos <= 8'hff;
    wr(ADDR_PULSE_WIDTH, 8'hff);
    load(8'h0a);
    send(0, lm);
    chk_runs(3, 256);
    chk_int(lm, lat0 + 255, "pulse start");
    miller_en <= 1'b0;
  endtask

  // symbol fields differ so a swapped select shows
  task automatic t_burst();
    int lx;
    wr(ADDR_BURST_LEN, 8'h01);
    burst_level <= 1'b1;
    symbol_select <= 1'b1;
    q.delete();
    load(8'h00);
    send(0, lx);
    chk_runs(1, 8 * ETU_CLKS);
    symbol_select <= 1'b0;
    send(0, lx);
    chk_runs(1, 16 * ETU_CLKS);
  endtask

  task automatic t_fill();
    int lx;
    q.delete();
    for (int i = 0; i < FIFO_DEPTH; i++) q.push_back(8'ha5 ^ (8'(i) * 8'h13));
    load(8'h08);
    @(posedge clk);
    #1 chk8({7'h0, tx_ready}, 8'h00, "full buffer refuses");
    send(0, lx);
    chk_bits();
    chk8({7'h0, tx_ready}, 8'h01, "buffer drained");
  endtask

  // ---------------------------------------------------------------
  // run control
  // ---------------------------------------------------------------
  task automatic close_out();
    if (n_mismatch == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // a clean run takes about 106k cycles; margin kept small so a hang ends soon
  initial begin
    repeat (120000) @(posedge clk);
    n_mismatch++;
    close_out();
  end

  initial begin
    {rst_n, reg_wr, reg_rd, tx_last, tx_valid, tx_start} = '0;
    {miller_en, burst_level, symbol_select} = '0;
    {reg_addr, reg_wdata, tx_byte, pulse_pos} = '0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs();
    t_grid();
    t_miller();
    t_burst();
    t_fill();
    close_out();
  end
endmodule
